//--- verilog/qd_dac.sv
// Device end: serial frame receiver, channel registers, load and clear control.
//
// How it works
// [RULE1] Bits count only while frame is low.
// [RULE2] Input bit shifts in on falling clock edge.
// [RULE3] Host keeps serial clock at most 30 MHz.
// [RULE4] Host holds input bit stable at falling edges.
// [RULE5] Daisy-chain or readback drives shift register out.
// [RULE6] Clear falling edge zeroes every DAC register.
// [RULE7] Strobe low: addressed DAC updates at frame end.
// [RULE8] Strobe high: input register only, DAC waits.
// [RULE9] Strobe falling edge moves all pending channels together.
// [RULE10] Host pulses the load strobe on load_req, or holds it low while load_tied_low is set.
// [RULE11] Serial commands set and read two port pins.
// [RULE12] Clamp input low forces outputs to zero volts.
// [RULE13] Clamp leaves every register unchanged.
// [RULE14] Standalone frame holds exactly twenty-four bits.
// [RULE15] Daisy-chain output changes on rising clock edge.
// [RULE16] Coding input picks offset binary or twos complement.
// [RULE17] Short frame is discarded, registers untouched.
`timescale 1ns/1ps
module qd_dac #(
  parameter int CNT_W = 8
) (
  input  wire logic                                            clock,
  input  wire logic                                            rst_b,
  qd_link_if.dac_mp                                            link,
  input  wire logic                                            coding_select,
  input  wire logic                                            gpio_pin_zero_level,
  output logic                                                 gpio_pin_zero_drive,
  output logic                                                 gpio_pin_zero_en,
  input  wire logic                                            gpio_pin_one_level,
  output logic                                                 gpio_pin_one_drive,
  output logic                                                 gpio_pin_one_en,
  output logic [qd_pkg::CHAN_COUNT-1:0][qd_pkg::DAC_BITS-1:0] dac_level,
  output logic                                                 outputs_clamped
);
  import qd_pkg::*;

  // ---------------------------------------------------------------
  // Core state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0]                         cnt;
    logic                                     frame_q;
    logic                                     sclk_q;
    logic                                     load_strobe_n_q;
    logic                                     clr_q;
    logic [CHAN_COUNT-1:0][DAC_BITS-1:0]      in_reg;
    logic [CHAN_COUNT-1:0][DAC_BITS-1:0]      dac_reg;
    logic [CHAN_COUNT-1:0][DAC_BITS-1:0]      level;
    logic [CHAN_COUNT-1:0]                    pend;
    logic                                     daisy;
    logic                                     rb_mode;
    logic [1:0]                               dir;
    logic [1:0]                               drive;
    logic                                     clamped;
    logic [FRAME_BITS-1:0]                    rb_word;
  } qd_core_t;

  localparam logic [CNT_W-1:0] FRAME_CNT = CNT_W'(FRAME_BITS);

  if (CNT_W < 6 || (2 ** CNT_W) <= FRAME_BITS) begin : g_chk
    $error("Bit counter too narrow for one frame.");
  end

  function automatic logic [CHAN_COUNT-1:0] chan_mask(input logic [2:0] ch);
    logic [CHAN_COUNT-1:0] m;
    m = '0;
    if (ch == CH_ALL) begin
      m = '1;
    end else if (int'(ch) < CHAN_COUNT) begin
      m[ch[1:0]] = 1'b1;
    end
    return m;
  endfunction : chan_mask

  qd_core_t              c_q;
  qd_core_t              c_d;
  logic [SY_WIDTH-1:0]   raw;
  logic [SY_WIDTH-1:0]   syn;
  logic [FRAME_BITS-1:0] sreg_q;
  logic [FRAME_BITS-1:0] sreg_d;
  logic [FRAME_BITS-1:0] base;
  logic                  started_q;
  logic                  sdo_q;
  logic [FRAME_BITS-1:0] word;
  logic                  frame_ok;
  logic [2:0]            ch;
  logic [DATA_BITS-1:0]  ctrl_rd;
  logic [CHAN_COUNT-1:0] mask;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_comb begin
    raw           = '0;
    raw[SY_FRAME] = link.frame_n;
    raw[SY_SCLK]  = link.sclk;
    raw[SY_LOAD_STROBE_N]  = link.load_strobe_n;
    raw[SY_CLR]   = link.clear_n;
    raw[SY_CLAMP] = link.output_clamp_n;
    raw[SY_CODE]  = coding_select;
    raw[SY_PIN0]  = gpio_pin_zero_level;
    raw[SY_PIN1]  = gpio_pin_one_level;
  end

  qd_sync #(
    .WIDTH (SY_WIDTH)
  ) u_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in (raw),
    .sync_out (syn)
  );

  // ---------------------------------------------------------------
  // Link domain
  // ---------------------------------------------------------------
  // The readback word and mode flags change only at frame end, so they are
  // steady for the whole frame in which this domain reads them.
  always_comb begin
    base   = (!started_q && c_q.rb_mode) ? c_q.rb_word : sreg_q;
    sreg_d = {base[FRAME_BITS-2:0], link.serial_in};
  end

  always_ff @(negedge link.sclk) begin
    if (!rst_b) begin
      sreg_q <= '0;
    end else if (!link.frame_n) begin // RULE1
      sreg_q <= sreg_d; // RULE2
    end
  end

  // Cleared by the frame itself because the link clock stops between frames.
  always_ff @(negedge link.sclk or posedge link.frame_n) begin
    if (link.frame_n) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  always_ff @(posedge link.sclk) begin
    sdo_q <= sreg_q[FRAME_BITS-1]; // RULE15
  end

  // Before the first edge the top bit shows directly, so no bit is lost.
  assign link.serial_out = (c_q.daisy || c_q.rb_mode) ?
                           (started_q ? sdo_q : base[FRAME_BITS-1]) : 1'b0; // RULE5

  // ---------------------------------------------------------------
  // Core decode
  // ---------------------------------------------------------------
  always_comb begin
    word     = sreg_q;
    ch       = word[CH_HI:CH_LO];
    mask     = chan_mask(ch);
    frame_ok = c_q.daisy ? (c_q.cnt >= FRAME_CNT) : (c_q.cnt == FRAME_CNT); // RULE14
    ctrl_rd  = '0;
    ctrl_rd[CTRL_DAISY] = c_q.daisy;
    ctrl_rd[CTRL_DIR0]  = c_q.dir[0];
    ctrl_rd[CTRL_OUT0]  = c_q.drive[0];
    ctrl_rd[CTRL_DIR1]  = c_q.dir[1];
    ctrl_rd[CTRL_OUT1]  = c_q.drive[1];
    ctrl_rd[CTRL_PIN0]  = syn[SY_PIN0]; // RULE11
    ctrl_rd[CTRL_PIN1]  = syn[SY_PIN1]; // RULE11
  end

  always_comb begin
    c_d         = c_q;
    c_d.frame_q = syn[SY_FRAME];
    c_d.sclk_q  = syn[SY_SCLK];
    c_d.load_strobe_n_q  = syn[SY_LOAD_STROBE_N];
    c_d.clr_q   = syn[SY_CLR];
    if (!syn[SY_FRAME] && c_q.sclk_q && !syn[SY_SCLK] && c_q.cnt != '1) begin // RULE1
      c_d.cnt = c_q.cnt + 1'b1;
    end
    if (syn[SY_FRAME] && !c_q.frame_q) begin
      c_d.cnt = '0;
      if (frame_ok) begin // RULE17
        c_d.rb_mode = word[RW_BIT];
        if (word[RW_BIT]) begin
          c_d.rb_word = {word[RW_BIT:CH_LO], DATA_BITS'(0)};
          if (word[SEL_HI:SEL_LO] == SEL_DATA) begin
            c_d.rb_word[DATA_BITS-1:0] = {c_q.in_reg[ch[1:0]], DAC_LO'(0)};
          end else if (word[SEL_HI:SEL_LO] == SEL_CTRL) begin
            c_d.rb_word[DATA_BITS-1:0] = ctrl_rd; // RULE11
          end
        end else if (word[SEL_HI:SEL_LO] == SEL_DATA) begin
          for (int i = 0; i < CHAN_COUNT; i++) begin
            if (mask[i]) begin
              c_d.in_reg[i] = word[DATA_BITS-1:DAC_LO];
              if (!syn[SY_LOAD_STROBE_N]) begin
                c_d.dac_reg[i] = word[DATA_BITS-1:DAC_LO]; // RULE7
                c_d.pend[i]    = 1'b0;
              end else begin
                c_d.pend[i]    = 1'b1; // RULE8
              end
            end
          end
        end else if (word[SEL_HI:SEL_LO] == SEL_CTRL) begin
          c_d.daisy    = word[CTRL_DAISY];
          c_d.dir[0]   = word[CTRL_DIR0]; // RULE11
          c_d.drive[0] = word[CTRL_OUT0];
          c_d.dir[1]   = word[CTRL_DIR1];
          c_d.drive[1] = word[CTRL_OUT1];
        end
      end
    end
    if (!syn[SY_LOAD_STROBE_N] && c_q.load_strobe_n_q) begin
      for (int i = 0; i < CHAN_COUNT; i++) begin
        if (c_d.pend[i]) begin
          c_d.dac_reg[i] = c_d.in_reg[i]; // RULE9
        end
      end
      c_d.pend = '0;
    end
    // Clear is applied last so it wins over a load in the same cycle.
    if (!syn[SY_CLR] && c_q.clr_q) begin
      for (int i = 0; i < CHAN_COUNT; i++) begin
        c_d.dac_reg[i] = CLEAR_CODE; // RULE6
      end
    end
    c_d.clamped = !syn[SY_CLAMP]; // RULE12
    for (int i = 0; i < CHAN_COUNT; i++) begin
      if (c_d.clamped) begin
        c_d.level[i] = CLAMP_CODE; // RULE12 RULE13
      end else if (syn[SY_CODE]) begin
        c_d.level[i] = c_d.dac_reg[i]; // RULE16
      end else begin
        c_d.level[i] = {~c_d.dac_reg[i][DAC_BITS-1], c_d.dac_reg[i][DAC_BITS-2:0]}; // RULE16
      end
    end
  end

  // ---------------------------------------------------------------
  // Core register
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      c_q         <= '0;
      c_q.frame_q <= 1'b1;
      c_q.level   <= {CHAN_COUNT{CLAMP_CODE}};
      c_q.clamped <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign gpio_pin_zero_drive = c_q.drive[0];
  assign gpio_pin_zero_en    = c_q.dir[0];
  assign gpio_pin_one_drive  = c_q.drive[1];
  assign gpio_pin_one_en     = c_q.dir[1];
  assign dac_level           = c_q.level;
  assign outputs_clamped     = c_q.clamped;

endmodule : qd_dac

//--- verilog/qd_pkg.sv
// Shared constants for the quad DAC serial update control block.
package qd_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int CHAN_COUNT = 4;
  localparam int DAC_BITS   = 14;
  localparam int RW_BIT     = 23;
  localparam int SEL_HI     = 22;
  localparam int SEL_LO     = 19;
  localparam int CH_HI      = 18;
  localparam int CH_LO      = 16;
  localparam int DATA_BITS  = 16;
  localparam int DAC_LO     = 2;

  localparam logic [3:0] SEL_DATA = 4'h0;
  localparam logic [3:0] SEL_CTRL = 4'h1;
  localparam logic [2:0] CH_ALL   = 3'h4;

  // ---------------------------------------------------------------
  // Control word fields
  // ---------------------------------------------------------------
  localparam int CTRL_DAISY = 0;
  localparam int CTRL_DIR0  = 1;
  localparam int CTRL_OUT0  = 2;
  localparam int CTRL_DIR1  = 3;
  localparam int CTRL_OUT1  = 4;
  localparam int CTRL_PIN0  = 5;
  localparam int CTRL_PIN1  = 6;

  localparam logic [DAC_BITS-1:0] CLEAR_CODE = 14'h0000;
  localparam logic [DAC_BITS-1:0] CLAMP_CODE = 14'h2000;

  // ---------------------------------------------------------------
  // Device synchroniser lanes
  // ---------------------------------------------------------------
  localparam int SY_FRAME = 0;
  localparam int SY_SCLK  = 1;
  localparam int SY_LOAD_STROBE_N  = 2;
  localparam int SY_CLR   = 3;
  localparam int SY_CLAMP = 4;
  localparam int SY_CODE  = 5;
  localparam int SY_PIN0  = 6;
  localparam int SY_PIN1  = 7;
  localparam int SY_WIDTH = 8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SCLK_MAX_MHZ  = 30;
  localparam int T4_NS         = 13;
  localparam int T5_NS         = 13;
  localparam int T6_NS         = 40;
  localparam int LOAD_STROBE_N_LOW_NS   = 10;
  localparam int CLR_LOW_NS    = 10;

  localparam int SCLK_MIN_PERIOD_PS = (1000000 + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;
  localparam int SCLK_HALF_CYC = (SCLK_MIN_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T4_CYC   = (T4_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T5_CYC   = (T5_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T6_CYC   = (T6_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOAD_STROBE_N_CYC = (LOAD_STROBE_N_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CLR_CYC  = (CLR_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : qd_pkg

//--- verilog/qd_link_if.sv
// Serial link and strobe wires between the host and the quad DAC.
`timescale 1ns/1ps
interface qd_link_if;
  logic frame_n;
  logic sclk;
  logic serial_in;
  logic serial_out;
  logic load_strobe_n;
  logic clear_n;
  logic output_clamp_n;

  modport host_mp (
    output frame_n,
    output sclk,
    output serial_in,
    input  serial_out,
    output load_strobe_n,
    output clear_n,
    output output_clamp_n
  );

  modport dac_mp (
    input  frame_n,
    input  sclk,
    input  serial_in,
    output serial_out,
    input  load_strobe_n,
    input  clear_n,
    input  output_clamp_n
  );
endinterface : qd_link_if

//--- verilog/qd_sync.sv
// Two flip-flop synchroniser for a bundle of independent levels.
`timescale 1ns/1ps
module qd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } qd_sync_t;

  qd_sync_t st_q;
  qd_sync_t st_d;

  if (WIDTH < 1) begin : g_chk
    $error("Synchroniser width must be at least one.");
  end

  always_comb begin
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;

endmodule : qd_sync

//--- verilog/qd_host.sv
// Host end: frames commands onto the serial link and drives the strobes.
`timescale 1ns/1ps
module qd_host #(
  parameter int HALF_CYC = qd_pkg::SCLK_HALF_CYC
) (
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  qd_link_if.host_mp                         link,
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire logic [qd_pkg::FRAME_BITS-1:0] cmd_word,
  output logic                               rsp_valid,
  output logic      [qd_pkg::FRAME_BITS-1:0] rsp_word,
  input  wire logic                          load_req,
  input  wire logic                          load_tied_low,
  input  wire logic                          clear_req,
  input  wire logic                          clamp_req
);
  import qd_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_LEAD = 5'b00010,
    H_LOW  = 5'b00100,
    H_HIGH = 5'b01000,
    H_GAP  = 5'b10000
  } qd_hstate_t;

  typedef struct packed {
    qd_hstate_t            state;
    logic [7:0]            tmr;
    logic [4:0]            nbit;
    logic [FRAME_BITS-1:0] tx;
    logic [FRAME_BITS-1:0] rx;
    logic                  frame_n;
    logic                  sclk;
    logic                  sdi;
    logic                  rsp_valid;
    logic [FRAME_BITS-1:0] rsp;
    logic [3:0]            load_strobe_n_tmr;
    logic [3:0]            clr_tmr;
    logic                  load_strobe_n_n;
    logic                  clr_n;
    logic                  clamp_n;
  } qd_host_t;

  // The link clock half period also covers the frame end hold time.
  if (HALF_CYC < SCLK_HALF_CYC || HALF_CYC < T5_CYC || HALF_CYC > 255) begin : g_chk
    $error("Serial clock half period out of range.");
  end

  qd_host_t h_q;
  qd_host_t h_d;
  logic     sdo_s;

  qd_sync #(
    .WIDTH (1)
  ) u_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in (link.serial_out),
    .sync_out (sdo_s)
  );

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  always_comb begin
    h_d           = h_q;
    h_d.rsp_valid = 1'b0;
    unique case (h_q.state)
      H_IDLE: begin
        if (cmd_valid) begin
          h_d.tx      = cmd_word;
          h_d.sdi     = cmd_word[FRAME_BITS-1];
          h_d.frame_n = 1'b0;
          h_d.nbit    = '0;
          h_d.tmr     = 8'(T4_CYC - 1);
          h_d.state   = H_LEAD;
        end
      end
      H_LEAD: begin
        if (h_q.tmr == '0) begin
          h_d.sclk  = 1'b0;
          h_d.tmr   = 8'(HALF_CYC - 1);
          h_d.state = H_LOW;
        end else begin
          h_d.tmr = h_q.tmr - 1'b1;
        end
      end
      H_LOW: begin
        if (h_q.tmr == '0) begin
          h_d.rx    = {h_q.rx[FRAME_BITS-2:0], sdo_s};
          h_d.tx    = {h_q.tx[FRAME_BITS-2:0], 1'b0};
          h_d.sdi   = h_q.tx[FRAME_BITS-2]; // RULE4
          h_d.sclk  = 1'b1;
          h_d.nbit  = h_q.nbit + 1'b1;
          h_d.tmr   = 8'(HALF_CYC - 1); // RULE3
          h_d.state = H_HIGH;
        end else begin
          h_d.tmr = h_q.tmr - 1'b1;
        end
      end
      H_HIGH: begin
        if (h_q.tmr != '0) begin
          h_d.tmr = h_q.tmr - 1'b1;
        end else if (h_q.nbit == 5'(FRAME_BITS)) begin
          h_d.frame_n   = 1'b1; // RULE1 RULE14
          h_d.rsp_valid = 1'b1;
          h_d.rsp       = h_q.rx;
          h_d.tmr       = 8'(T6_CYC - 1);
          h_d.state     = H_GAP;
        end else begin
          h_d.sclk  = 1'b0;
          h_d.tmr   = 8'(HALF_CYC - 1);
          h_d.state = H_LOW;
        end
      end
      H_GAP: begin
        if (h_q.tmr == '0) begin
          h_d.state = H_IDLE;
        end else begin
          h_d.tmr = h_q.tmr - 1'b1;
        end
      end
      default: begin
        h_d.state = H_IDLE;
      end
    endcase

    // ---------------------------------------------------------------
    // Strobes
    // ---------------------------------------------------------------
    if (h_q.load_strobe_n_tmr != '0) begin
      h_d.load_strobe_n_tmr = h_q.load_strobe_n_tmr - 1'b1;
    end else if (load_req) begin
      h_d.load_strobe_n_tmr = 4'(LOAD_STROBE_N_CYC);
    end
    if (h_q.clr_tmr != '0) begin
      h_d.clr_tmr = h_q.clr_tmr - 1'b1;
    end else if (clear_req) begin
      h_d.clr_tmr = 4'(CLR_CYC);
    end
    h_d.load_strobe_n_n  = !load_tied_low && (h_d.load_strobe_n_tmr == '0); // RULE10
    h_d.clr_n   = (h_d.clr_tmr == '0);
    h_d.clamp_n = !clamp_req;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      h_q         <= '0;
      h_q.state   <= H_IDLE;
      h_q.frame_n <= 1'b1;
      h_q.sclk    <= 1'b1;
      h_q.load_strobe_n_n  <= 1'b1;
      h_q.clr_n   <= 1'b1;
      h_q.clamp_n <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign cmd_ready           = (h_q.state == H_IDLE);
  assign rsp_valid           = h_q.rsp_valid;
  assign rsp_word            = h_q.rsp;
  assign link.frame_n        = h_q.frame_n;
  assign link.sclk           = h_q.sclk;
  assign link.serial_in      = h_q.sdi;
  assign link.load_strobe_n  = h_q.load_strobe_n_n;
  assign link.clear_n        = h_q.clr_n;
  assign link.output_clamp_n = h_q.clamp_n;

endmodule : qd_host

//--- test/qd_link_properties.sv
// Timing checks on the serial link wires between host and device.
`timescale 1ns/1ps
module qd_link_properties (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic load_strobe_n,
  input wire logic clear_n,
  input wire logic output_clamp_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // ---------------------------------------------------------------
  // Falling edge count within a frame
  // ---------------------------------------------------------------
  logic       sclk_q;
  logic [4:0] fall_cnt_q;

  always_ff @(posedge clock) begin
    sclk_q <= sclk;
    if (!rst_b || frame_n) begin
      fall_cnt_q <= 5'h00;
    end else if (sclk_q && !sclk) begin
      fall_cnt_q <= fall_cnt_q + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // Link properties
  // ---------------------------------------------------------------
  AST_SCLK_IDLE: assert property (frame_n |-> sclk)
    else $error("serial clock low outside a frame");
  AST_FRAME_SETUP: assert property ($fell(frame_n) |-> sclk ##1 sclk ##1 !sclk)
    else $error("first clock fall not two cycles after frame start");
  AST_FRAME_GAP: assert property ($rose(frame_n) |-> frame_n [*5])
    else $error("frame gap shorter than five cycles");
  AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*3] ##1 sclk)
    else $error("serial clock low phase not three cycles");
  AST_DATA_STABLE: assert property ($fell(sclk) |-> $stable(serial_in))
    else $error("serial input moved at clock fall");
  AST_FRAME_BITS: assert property ($rose(frame_n) |-> fall_cnt_q == 5'h18)
    else $error("frame did not hold 24 clock falls");
  AST_OUT_ON_RISE: assert property (
      !frame_n && !$past(frame_n) && $changed(serial_out) |-> $rose(sclk))
    else $error("serial output moved away from a clock rise");
  AST_CLEAR_PULSE: assert property ($fell(clear_n) |-> !clear_n [*2] ##1 clear_n)
    else $error("clear pulse not two cycles low");
  AST_LOAD_PULSE: assert property ($fell(load_strobe_n) |-> !load_strobe_n [*2])
    else $error("load strobe low for under two cycles");
endmodule : qd_link_properties

//--- test/tb.sv
// Testbench joining the host end and the device end across the link.
`timescale 1ns/1ps
module tb;
  import qd_pkg::*;
  typedef struct { logic [23:0] word; int ch; logic [15:0] data; } qd_row_t;
  logic clock, rst_b, cmd_valid, cmd_ready, rsp_valid, load_req, load_tied_low;
  logic clear_req, clamp_req, coding_select, outputs_clamped;
  logic [FRAME_BITS-1:0] cmd_word, rsp_word;
  logic pin0_drive, pin0_en, pin1_drive, pin1_en, pin0_level, pin1_level;
  logic [CHAN_COUNT-1:0][DAC_BITS-1:0] dac_level;
  logic [3:0][15:0] cur;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  qd_row_t rows [4] = '{'{24'h00FFFC, 0, 16'hFFFC}, '{24'h010004, 1, 16'h0004},
                        '{24'h02A5A4, 2, 16'hA5A4}, '{24'h038000, 3, 16'h8000}};

  qd_link_if link ();
  // Port pins carry weak pull-ups, so a pin nobody drives reads high.
  assign pin0_level = pin0_en ? pin0_drive : 1'h1;
  assign pin1_level = pin1_en ? pin1_drive : 1'h1;

  qd_host qd_host_inst (.clock(clock), .rst_b(rst_b), .link(link.host_mp),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
    .rsp_valid(rsp_valid), .rsp_word(rsp_word), .load_req(load_req),
    .load_tied_low(load_tied_low), .clear_req(clear_req), .clamp_req(clamp_req));
  qd_dac qd_dac_inst (.clock(clock), .rst_b(rst_b), .link(link.dac_mp),
    .coding_select(coding_select), .gpio_pin_zero_level(pin0_level),
    .gpio_pin_zero_drive(pin0_drive), .gpio_pin_zero_en(pin0_en),
    .gpio_pin_one_level(pin1_level), .gpio_pin_one_drive(pin1_drive),
    .gpio_pin_one_en(pin1_en), .dac_level(dac_level), .outputs_clamped(outputs_clamped));
  qd_link_properties qd_link_properties_inst (.clock(clock), .rst_b(rst_b),
    .frame_n(link.frame_n), .sclk(link.sclk), .serial_in(link.serial_in),
    .serial_out(link.serial_out), .load_strobe_n(link.load_strobe_n),
    .clear_n(link.clear_n), .output_clamp_n(link.output_clamp_n));

  // ---------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ---------------------------------------------------------------
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  // A whole run needs about 2000 cycles; the margin covers a slow frame.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic logic [23:0] lvl(input logic [15:0] d, input logic cs);
    return 24'({d[15] ^ ~cs, d[14:2]});
  endfunction : lvl

  task automatic chk_all(input logic cs);
    for (int c = 0; c < 4; c++) begin
      chk("dac_level", lvl(cur[c], cs), 24'(dac_level[c]));
    end
  endtask : chk_all

  task automatic send(input logic [23:0] w);
    int k;
    k = 0;
    while (cmd_ready !== 1'h1 && k < 400) begin
      @(negedge clock);
      k++;
    end
    cmd_word = w;
    cmd_valid = 1'h1;
    @(negedge clock);
    cmd_valid = 1'h0;
    k = 0;
    while (rsp_valid !== 1'h1 && k < 400) begin
      @(negedge clock);
      k++;
    end
    chk("rsp_valid", 24'h1, 24'(rsp_valid));
    repeat (8) @(negedge clock);
  endtask : send

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_b, cmd_valid, load_req, clear_req, clamp_req, cmd_word} = '0;
    load_tied_low = 1'h1;
    coding_select = 1'h1;
    repeat (2) @(negedge clock);
    chk("clamped_in_reset", 24'h1, 24'(outputs_clamped));
    chk("level_in_reset", 24'(CLAMP_CODE), 24'(dac_level[0]));
    rst_b = 1'h1;
    repeat (10) @(negedge clock);
    chk("clamped_after_reset", 24'h0, 24'(outputs_clamped));
    for (int i = 0; i < 4; i++) begin
      send(rows[i].word);
      cur[rows[i].ch] = rows[i].data;
      chk("dac_level", lvl(rows[i].data, 1'h1), 24'(dac_level[rows[i].ch]));
    end
    clamp_req = 1'h1;
    repeat (10) @(negedge clock);
    chk("clamped", 24'h1, 24'(outputs_clamped));
    chk("clamp_level", 24'(CLAMP_CODE), 24'(dac_level[2]));
    clamp_req = 1'h0;
    repeat (10) @(negedge clock);
    chk_all(1'h1);
    load_tied_low = 1'h0;
    repeat (5) @(negedge clock);
    send(24'h001234);
    send(24'h034000);
    chk_all(1'h1);
    load_req = 1'h1;
    @(negedge clock);
    load_req = 1'h0;
    repeat (10) @(negedge clock);
    cur[0] = 16'h1234;
    cur[3] = 16'h4000;
    chk_all(1'h1);
    clear_req = 1'h1;
    @(negedge clock);
    clear_req = 1'h0;
    repeat (10) @(negedge clock);
    cur = '0;
    chk_all(1'h1);
    coding_select = 1'h0;
    repeat (10) @(negedge clock);
    chk_all(1'h0);
    coding_select = 1'h1;
    send(24'h080006);
    chk("pin_setup", 24'hC, 24'({pin0_en, pin0_drive, pin1_en, pin1_drive}));
    send(24'h880000);
    send(24'h880000);
    chk("readback", 24'({8'h88, 7'h66}), 24'({rsp_word[23:16], rsp_word[6:0]}));
    // The input register survives the clear, so channel zero still reads back its last write.
    send(24'h800000);
    send(24'h080001);
    chk("readback_data", 24'h801234, rsp_word);
    send(24'h080000);
    chk("daisy_out", 24'h080001, rsp_word);
    final_report();
  end
endmodule : tb
